// ===== hw/dacc_control.sv
// Top: converter control logic with APB register slave
// Notes on behaviour
// - Enable bit zero of control turns the converter on; clearing turns off.
// - While enabled and ready, each high byte value write starts a new conversion.
// - While disabled, a value write waits; setting enable starts that conversion.
// - Output updates on a high byte write or when the core becomes ready; low byte alone changes nothing.
// - Ten-bit value lives in bits 15:6; low two bits 7:6, rest upper byte.
// - Output buffer enable bit six powers buffer and drives the pin.
// - Enabled converter feeds unbuffered output internally even with buffer off.
// - Standby run bit seven keeps converter and buffer alive in standby.
// - Without standby run, standby stops conversion, powers converter and buffer down.
// - Leaving such standby repowers converter, buffer if enabled, waits start-up time.
// - Power-down sleep turns converter and buffer off regardless of standby run.
module dacc_control #(
   parameter int STARTUP_CYCLES = dacc_pkg::STARTUP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] sleepMode,
   output dacc_pkg::dacc_analog_t analogCtl
);
   // Refuse a start-up count the timer cannot serve
   if (STARTUP_CYCLES < 1) begin : gBadStartup
      $error("start-up count must be positive");
   end

   // =====================================================================
   // Bus decode
   function automatic logic isAddr(input logic [11:0] a, input logic [11:0] target);
      return a[11:2] == target[11:2];
   endfunction

   logic access;
   logic wrEn;
   logic ctrlHit;
   logic valueHit;
   logic statusHit;
   logic mapped;
   logic ctrlWr;
   logic valueLowWr;
   logic valueHighWr;
   logic [1:0] sleepS1_r;
   logic [1:0] sleepS2_r;

   assign access = psel && penable && clkEn;
   assign wrEn = access && pwrite;
   assign ctrlHit = isAddr(paddr, dacc_pkg::CONTROL_OFFSET);
   assign valueHit = isAddr(paddr, dacc_pkg::VALUE_ADDR);
   assign statusHit = isAddr(paddr, dacc_pkg::STATUS_ADDR);
   assign mapped = ctrlHit || valueHit || statusHit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign ctrlWr = wrEn && ctrlHit && pstrb[0];
   assign valueLowWr = wrEn && valueHit && pstrb[0];
   assign valueHighWr = wrEn && valueHit && pstrb[1];

   // =====================================================================
   // Sleep request from the power manager, another domain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleepS1_r <= 2'h0;
         sleepS2_r <= 2'h0;
      end else if (clkEn) begin
         sleepS1_r <= sleepMode;
         sleepS2_r <= sleepS1_r;
      end
   end

   dacc_pkg::dacc_sleep_t sleepState;
   assign sleepState = dacc_pkg::dacc_sleep_t'(sleepS2_r);

   // =====================================================================
   // Control register
   logic [7:0] control_r;
   logic enable;
   logic outBufEn;
   logic standbyRun;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_r <= dacc_pkg::CTRL_RESET;
      end else if (ctrlWr) begin
         control_r <= pwdata[7:0] & dacc_pkg::CTRL_WRITE_MASK;
      end
   end

   assign enable = control_r[dacc_pkg::CTRL_ENABLE_BIT];
   assign outBufEn = control_r[dacc_pkg::CTRL_OUTBUF_BIT];
   assign standbyRun = control_r[dacc_pkg::CTRL_STBYRUN_BIT];

   // =====================================================================
   // Value register, 10 bits left-aligned in 16
   logic [15:0] value_r;
   logic [15:0] valueNxt;

   always_comb begin
      valueNxt = value_r;
      if (valueLowWr) begin
         valueNxt[7:0] = pwdata[7:0] & dacc_pkg::VALUE_WRITE_MASK[7:0];
      end
      if (valueHighWr) begin
         valueNxt[15:8] = pwdata[15:8];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_r <= dacc_pkg::VALUE_RESET;
      end else if (clkEn) begin
         value_r <= valueNxt;
      end
   end

   // =====================================================================
   // Power gating for standby and power-down
   logic gated;
   logic corePower;
   logic coreReady;

   always_comb begin
      case (sleepState)
         dacc_pkg::DACC_SLEEP_STANDBY: gated = !standbyRun;
         dacc_pkg::DACC_SLEEP_POWERDOWN: gated = 1'b1;
         default: gated = 1'b0;
      endcase
   end

   assign corePower = enable && !gated;

   dacc_startup_timer #(
      .CYCLES(STARTUP_CYCLES)
   ) startupTimer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .powered(corePower),
      .ready(coreReady)
   );

   // =====================================================================
   // Conversion sequencing
   // A high-byte write while not ready leaves a pending start; it fires once
   // enable is set and the core has settled, with the last value written before then.
   logic pending_r;
   logic startNow;
   logic startPulse_r;
   logic [dacc_pkg::VALUE_WIDTH-1:0] convValue_r;
   logic wasReady_r;

   assign startNow = coreReady && (valueHighWr || pending_r);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_r <= 1'b0;
      end else if (clkEn) begin
         if (valueHighWr && !coreReady) begin
            pending_r <= 1'b1;
         end else if (startNow) begin
            pending_r <= 1'b0;
         end else if (coreReady && !wasReady_r) begin
            pending_r <= 1'b0;
         end
      end
   end

   // Repowering after standby restarts the output with the held value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wasReady_r <= 1'b0;
      end else if (clkEn) begin
         wasReady_r <= coreReady;
      end
   end

   logic resumeStart;
   assign resumeStart = coreReady && !wasReady_r && !startNow;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         startPulse_r <= 1'b0;
         convValue_r <= '0;
      end else if (clkEn) begin
         startPulse_r <= startNow || resumeStart;
         if (startNow) begin
            convValue_r <= valueNxt[15:dacc_pkg::VALUE_LSB];
         end else if (resumeStart) begin
            convValue_r <= value_r[15:dacc_pkg::VALUE_LSB];
         end
      end else begin
         startPulse_r <= 1'b0;
      end
   end

   // =====================================================================
   // Analog controls
   logic coreOn_r;
   logic bufferOn_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         coreOn_r <= 1'b0;
         bufferOn_r <= 1'b0;
      end else if (clkEn) begin
         coreOn_r <= corePower;
         bufferOn_r <= corePower && outBufEn;
      end
   end

   assign analogCtl.coreOn = coreOn_r;
   assign analogCtl.bufferOn = bufferOn_r;
   assign analogCtl.unbufferedOn = coreOn_r;
   assign analogCtl.convStart = startPulse_r;
   assign analogCtl.convValue = convValue_r;

   // =====================================================================
   // Read data
   logic [31:0] rdNxt;

   always_comb begin
      rdNxt = 32'h0000_0000;
      if (ctrlHit) begin
         rdNxt[7:0] = control_r;
      end else if (valueHit) begin
         rdNxt[15:0] = value_r;
      end else if (statusHit) begin
         rdNxt[3:0] = {pending_r, coreReady, bufferOn_r, coreOn_r};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (clkEn && psel && !penable && !pwrite) begin
         prdata <= rdNxt;
      end
   end

   // =====================================================================
   // Checks
   sequence seqHighWrite;
      clkEn && valueHighWr && coreReady;
   endsequence

   AST_START_ON_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqHighWrite |=> startPulse_r)
      else $error("high byte write while ready gave no start");
   AST_LOW_NO_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && valueLowWr && !valueHighWr && !pending_r && !resumeStart |=> !startPulse_r)
      else $error("low byte write alone started a conversion");
   AST_PULSE_SINGLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      startPulse_r && clkEn && !$past(startNow) |=> !startPulse_r || $past(startNow))
      else $error("start pulse longer than one cycle");
   AST_VALUE_STABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      !startPulse_r ##1 !startPulse_r |-> $stable(convValue_r))
      else $error("latched value changed without a start");
   AST_DISABLED_NO_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      !enable && !coreReady |=> !startPulse_r)
      else $error("start while disabled");
   AST_POWERDOWN_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && sleepState == dacc_pkg::DACC_SLEEP_POWERDOWN |=> !coreOn_r && !bufferOn_r)
      else $error("core or buffer on in power-down");
   AST_STANDBY_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && sleepState == dacc_pkg::DACC_SLEEP_STANDBY && !standbyRun |=> !coreOn_r)
      else $error("core on in standby without standby run");
   AST_STANDBY_RUN: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && sleepState == dacc_pkg::DACC_SLEEP_STANDBY && standbyRun && enable |=> coreOn_r)
      else $error("core dropped in standby with standby run");
   AST_BUFFER_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
      bufferOn_r |-> coreOn_r)
      else $error("buffer on without core");
   AST_ENABLE_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && enable && sleepState == dacc_pkg::DACC_SLEEP_ACTIVE |=> coreOn_r)
      else $error("enabled core not on");
   AST_NO_START_UNREADY: assert property (@(posedge core_clk) disable iff (!rst_n)
      startPulse_r |-> $past(coreReady))
      else $error("start before core ready");

   // =====================================================================
   // Checks on the value path, pending starts and the start-up wait
   sequence seqHighOnly;
      clkEn && valueHighWr && !valueLowWr && coreReady;
   endsequence

   sequence seqBothBytes;
      clkEn && valueHighWr && valueLowWr && coreReady;
   endsequence

   sequence seqHeldPending;
      clkEn && pending_r && coreReady;
   endsequence

   AST_HIGH_ONLY_VALUE: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqHighOnly |=> convValue_r == {$past(pwdata[15:8]), $past(value_r[7:6])})
      else $error("high byte start latched a wrong value");
   AST_BOTH_BYTES_VALUE: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqBothBytes |=> convValue_r == {$past(pwdata[15:8]), $past(pwdata[7:6])})
      else $error("full word start latched a wrong value");
   AST_PENDING_FIRES: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqHeldPending |=> startPulse_r && !pending_r)
      else $error("pending start not issued once ready");
   AST_PENDING_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && valueHighWr && !coreReady |=> pending_r)
      else $error("high byte write while unready left no pending start");
   AST_VALUE_LOW_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
      value_r[5:0] == 6'h00)
      else $error("unused value bits not zero");
   AST_LOW_HOLDS_OUTPUT: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && valueLowWr && !valueHighWr && !pending_r && !resumeStart |=> $stable(convValue_r))
      else $error("low byte write changed the output value");
   AST_RESUME_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && coreReady && !wasReady_r |=> startPulse_r)
      else $error("no start after the core became ready");
   AST_UNREADY_NO_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      !coreReady |=> !startPulse_r)
      else $error("start issued during start-up time");
   AST_BUFFER_NEEDS_EN: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && !outBufEn |=> !bufferOn_r)
      else $error("buffer on with its enable bit clear");
   AST_TAP_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && enable && !outBufEn && sleepState == dacc_pkg::DACC_SLEEP_ACTIVE
      |=> coreOn_r && !bufferOn_r)
      else $error("internal output path wrong with buffer off");
   AST_DISABLE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && !enable |=> !coreOn_r && !bufferOn_r)
      else $error("core or buffer on while disabled");
   AST_CTRL_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
      (control_r & ~dacc_pkg::CTRL_WRITE_MASK) == 8'h00)
      else $error("reserved control bits set");
   AST_STANDBY_RUN_BUF: assert property (@(posedge core_clk) disable iff (!rst_n)
      clkEn && sleepState == dacc_pkg::DACC_SLEEP_STANDBY && standbyRun && outBufEn
      && enable |=> bufferOn_r)
      else $error("buffer dropped in standby with standby run");
endmodule // dacc_control

// ===== hw/dacc_pkg.sv
// Package: register map, field positions and timing for the converter control block
package dacc_pkg;
   // =====================================================================
   // Register map
   localparam logic [11:0] CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] VALUE_OFFSET = 12'h002;
   localparam logic [11:0] VALUE_ADDR = 12'h008;
   localparam logic [11:0] STATUS_ADDR = 12'h00C;
   // =====================================================================
   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_OUTBUF_BIT = 6;
   localparam int CTRL_STBYRUN_BIT = 7;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hC1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [15:0] VALUE_WRITE_MASK = 16'hFFC0;
   localparam int VALUE_LSB = 6;
   localparam int VALUE_WIDTH = 10;
   // =====================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STARTUP_NS = 1000;
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =====================================================================
   // Types
   typedef enum logic [1:0] {
      DACC_SLEEP_ACTIVE,
      DACC_SLEEP_IDLE,
      DACC_SLEEP_STANDBY,
      DACC_SLEEP_POWERDOWN
   } dacc_sleep_t;
   typedef struct packed {
      logic coreOn;
      logic bufferOn;
      logic unbufferedOn;
      logic convStart;
      logic [VALUE_WIDTH-1:0] convValue;
   } dacc_analog_t;
endpackage

// ===== hw/dacc_startup_timer.sv
// Start-up delay counter run after the converter core is powered
module dacc_startup_timer #(
   parameter int CYCLES = dacc_pkg::STARTUP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic powered,
   output logic ready
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] TOP = CW'(CYCLES);
   logic [CW-1:0] count_r;

   // Refuse a count that the counter cannot serve
   if (CYCLES < 1) begin : gBadCycles
      $error("start-up count must be at least one cycle");
   end

   // =====================================================================
   // Counter restarts on every loss of power
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (clkEn) begin
         if (!powered) begin
            count_r <= '0;
         end else if (count_r != TOP) begin
            count_r <= count_r + CW'(1);
         end
      end
   end

   assign ready = powered && (count_r == TOP);
endmodule // dacc_startup_timer

// ===== verification/dacc_analog_model.sv
// Behavioural model of the analog converter core and its pin buffer
module dacc_analog_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire dacc_pkg::dacc_analog_t analogCtl,
   output logic [7:0] startCount,
   output logic [9:0] pinLevel,
   output logic [9:0] tapLevel,
   output logic longPulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_r;
   logic prevStart_r;
   // =====================================================================
   // Conversion latch
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_r <= 10'h000;
         prevStart_r <= 1'b0;
         startCount <= 8'h00;
         longPulse <= 1'b0;
      end else begin
         prevStart_r <= analogCtl.convStart;
         if (analogCtl.convStart) begin
            held_r <= analogCtl.convValue;
            startCount <= startCount + 8'h01;
         end
         if (analogCtl.convStart && prevStart_r) longPulse <= 1'b1;
      end
   end
   // =====================================================================
   // Outputs: a dead path shows the inverse so a stale value never matches
   assign pinLevel = (analogCtl.coreOn && analogCtl.bufferOn) ? held_r : ~held_r;
   assign tapLevel = analogCtl.unbufferedOn ? held_r : ~held_r;
endmodule // dacc_analog_model

// ===== verification/tb_dac_control_logic.sv
// Self-checking testbench for the converter control block
module tb_dac_control_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr, errSeen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] sleepMode;
   dacc_pkg::dacc_analog_t analogCtl;
   logic [7:0] startCount;
   logic [9:0] pinLevel, tapLevel;
   logic longPulse;
   int err_count, total_checks;
   // =====================================================================
   // Instances; short start-up keeps the run brief
   dacc_control #(.STARTUP_CYCLES(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleepMode(sleepMode), .analogCtl(analogCtl));
   dacc_analog_model model (.core_clk(core_clk), .rst_n(rst_n), .analogCtl(analogCtl),
      .startCount(startCount), .pinLevel(pinLevel), .tapLevel(tapLevel), .longPulse(longPulse));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // =====================================================================
   // Bus and compare tasks
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chkb(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task setSleep(input logic [1:0] m);
      @(posedge core_clk);
      sleepMode <= m;
   endtask
   task waitStarts(input logic [7:0] n);
      int k;
      k = 0;
      while (startCount !== n && k < 40) begin
         @(negedge core_clk);
         k++;
      end
      chk("start count", {24'h0, n}, {24'h0, startCount});
   endtask
   task waitCore(input logic e);
      int k;
      k = 0;
      while (analogCtl.coreOn !== e && k < 40) begin
         @(negedge core_clk);
         k++;
      end
      chkb("core on", e, analogCtl.coreOn);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // =====================================================================
   // Scenarios
   task t_reset;
      apb(1'b0, dacc_pkg::CONTROL_OFFSET, 32'h0, 4'hF);
      chk("control reset", 32'h0, rd);
      apb(1'b0, dacc_pkg::VALUE_ADDR, 32'h0, 4'hF);
      chk("value reset", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0, 4'hF);
      chkb("unmapped error", 1'b1, errSeen);
      chk("unmapped data", 32'h0, rd);
      $display("TEST reset done");
   endtask
   task t_pending;
      // Value first, enable last
      apb(1'b1, dacc_pkg::VALUE_ADDR, 32'h0000A940, 4'h3);
      idle(10);
      chk("start while off", 32'h0, {24'h0, startCount});
      apb(1'b0, dacc_pkg::STATUS_ADDR, 32'h0, 4'h0);
      chk("status pending", 32'h8, rd);
      apb(1'b1, dacc_pkg::CONTROL_OFFSET, 32'h01, 4'h1);
      waitCore(1'b1);
      chkb("buffer off", 1'b0, analogCtl.bufferOn);
      waitStarts(8'h01);
      chk("internal level", 32'h2A5, {22'h0, tapLevel});
      apb(1'b0, dacc_pkg::STATUS_ADDR, 32'h0, 4'h0);
      chk("status running", 32'h5, rd);
      $display("TEST pending done");
   endtask
   task t_bytes;
      apb(1'b1, dacc_pkg::VALUE_ADDR, 32'h000000C0, 4'h1);
      idle(10);
      chk("low byte only", 32'h2A5, {22'h0, tapLevel});
      apb(1'b1, dacc_pkg::VALUE_ADDR, 32'h00005A00, 4'h2);
      waitStarts(8'h02);
      chk("split value", 32'h16B, {22'h0, tapLevel});
      apb(1'b0, dacc_pkg::VALUE_ADDR, 32'h0, 4'hF);
      chk("value readback", 32'h00005AC0, rd);
      apb(1'b1, dacc_pkg::VALUE_ADDR, 32'h0000FF00, 4'h2);
      waitStarts(8'h03);
      chk("top value", 32'h3FF, {22'h0, tapLevel});
      @(posedge core_clk);
      clkEn <= 1'b0;
      apb(1'b1, dacc_pkg::VALUE_ADDR, 32'h00001100, 4'h2);
      clkEn <= 1'b1;
      idle(10);
      chk("frozen write", 32'h3, {24'h0, startCount});
      $display("TEST bytes done");
   endtask
   task t_sleep;
      apb(1'b1, dacc_pkg::CONTROL_OFFSET, 32'h41, 4'h1);
      idle(3);
      chk("pin level", 32'h3FF, {22'h0, pinLevel});
      setSleep(2'h2);
      waitCore(1'b0);
      chkb("buffer in standby", 1'b0, analogCtl.bufferOn);
      setSleep(2'h0);
      waitCore(1'b1);
      chkb("buffer back", 1'b1, analogCtl.bufferOn);
      chk("no early start", 32'h3, {24'h0, startCount});
      waitStarts(8'h04);
      setSleep(2'h1);
      idle(6);
      chkb("core in idle", 1'b1, analogCtl.coreOn);
      setSleep(2'h0);
      apb(1'b1, dacc_pkg::CONTROL_OFFSET, 32'hC1, 4'h1);
      setSleep(2'h2);
      idle(10);
      chkb("core kept", 1'b1, analogCtl.coreOn);
      chkb("buffer kept", 1'b1, analogCtl.bufferOn);
      setSleep(2'h3);
      waitCore(1'b0);
      chkb("buffer power-down", 1'b0, analogCtl.bufferOn);
      setSleep(2'h0);
      waitCore(1'b1);
      apb(1'b1, dacc_pkg::CONTROL_OFFSET, 32'h00, 4'h1);
      waitCore(1'b0);
      chkb("tap off", 1'b0, analogCtl.unbufferedOn);
      chkb("pulse width", 1'b0, longPulse);
      $display("TEST sleep done");
   endtask
   // =====================================================================
   // Main sequence and watchdog
   initial begin
      err_count = 0;
      total_checks = 0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      sleepMode = 2'h0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset;
      t_pending;
      t_bytes;
      t_sleep;
      complete_run;
   end
   initial begin
      #100000;
      err_count++;
      complete_run;
   end
endmodule // tb_dac_control_logic
